// file: hw/sccr_pkg.sv
// Package with the constants and carriers of the configuration register bank.
package sccr_pkg;

  // I/O port addresses of the index and data ports.
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA  = 16'h0024;

  // Register indices.
  localparam logic [7:0] IDX_CONTROL_ONE  = 8'h20;
  localparam logic [7:0] IDX_CONTROL_TWO  = 8'h21;
  localparam logic [7:0] IDX_SHADOW_ONE   = 8'h22;
  localparam logic [7:0] IDX_SHADOW_TWO   = 8'h23;
  localparam logic [7:0] IDX_DRAM_ONE     = 8'h24;
  localparam logic [7:0] IDX_DRAM_TWO     = 8'h25;
  localparam logic [7:0] IDX_SHADOW_THREE = 8'h26;
  localparam logic [7:0] IDX_CONTROL_THREE = 8'h27;

  // Reset values; control_one top bits come from the revision parameter.
  localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO   = 8'h00;
  localparam logic [7:0] RST_SHADOW_ONE    = 8'h84;
  localparam logic [7:0] RST_SHADOW_TWO    = 8'h00;
  localparam logic [7:0] RST_DRAM_ONE      = 8'h87;
  localparam logic [7:0] RST_DRAM_TWO      = 8'hf0;
  localparam logic [7:0] RST_SHADOW_THREE  = 8'h00;
  localparam logic [7:0] RST_CONTROL_THREE = 8'h80;

  // Writable masks; zero bits are read-only or reserved and read as zero, except control_one bits 7:6, which read the revision.
  localparam logic [7:0] WMASK_CONTROL_ONE   = 8'h3f;
  localparam logic [7:0] WMASK_SHADOW_ONE    = 8'hfd;
  localparam logic [7:0] WMASK_DRAM_ONE      = 8'hf7;
  localparam logic [7:0] WMASK_DRAM_TWO      = 8'hfb;
  localparam logic [7:0] WMASK_SHADOW_THREE  = 8'h7f;
  localparam logic [7:0] WMASK_CONTROL_THREE = 8'h80;

  // Field positions.
  localparam int C1_BURST_WAIT = 5;
  localparam int C1_EARLY_OE   = 4;
  localparam int C1_SINGLE_ALE = 3;
  localparam int C1_AT_WAIT    = 2;
  localparam int C1_HALT_RESET = 1;
  localparam int C1_FAST_RESET = 0;
  localparam int C2_BYTE_SWAP  = 7;
  localparam int C2_KBD_NOW    = 6;
  localparam int C2_PARITY_OFF = 5;
  localparam int C2_CACHE_EN   = 4;
  localparam int C2_SIZE_LO    = 2;
  localparam int C2_READ_FAST  = 1;
  localparam int C2_WRITE_ZERO = 0;
  localparam int S1_ROM_F      = 7;
  localparam int S1_SHADOW_D   = 6;
  localparam int S1_SHADOW_E   = 5;
  localparam int S1_WP_D       = 4;
  localparam int S1_WP_E       = 3;
  localparam int S1_HIDDEN_OFF = 2;
  localparam int S1_SLOW_REF   = 0;
  localparam int D1_MODE       = 7;
  localparam int D1_TYPE01_LO  = 4;
  localparam int D2_READ_LO    = 6;
  localparam int D2_WRITE_LO   = 4;
  localparam int D2_FAST_DEC   = 3;
  localparam int D2_CLK_STRAP  = 0;
  localparam int S3_COPY       = 6;
  localparam int S3_WP_C       = 5;
  localparam int S3_SHADOW_C   = 4;
  localparam int C3_NONCACHE   = 7;

  // Wait-state bases and emulated keyboard reset delay.
  localparam logic [2:0] READ_BASE_WAIT  = 3'h3;
  localparam logic [2:0] WRITE_BASE_WAIT = 3'h2;
  localparam int         KBD_DELAY_NS    = 2000;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         KBD_DELAY_CYC   = KBD_DELAY_NS / CLK_PERIOD_NS;

  // Bank device size codes.
  typedef enum logic [1:0] {SCCR_EMPTY, SCCR_256K, SCCR_1M, SCCR_4M} sccr_size_t;

  // Decoded settings handed to the consuming state machines.
  typedef struct packed {
    logic       burst_wait;
    logic       early_oe;
    logic       single_ale;
    logic       at_wait;
    logic       halt_reset;
    logic       fast_reset;
    logic       byte_swap;
    logic       kbd_now;
    logic       parity_en;
    logic       cache_en;
    logic       dram_burst;
    logic [1:0] cache_size;
    logic       read_fast;
    logic       write_zero;
    logic       hidden_en;
    logic       slow_refresh;
    logic       noncache_en;
    logic       fast_decode;
    logic [2:0] read_wait;
    logic [2:0] write_wait;
    logic [1:0] clk_select;
  } sccr_cfg_t;

  // Shadow map settings.
  typedef struct packed {
    logic       rom_f;
    logic       shadow_d;
    logic       shadow_e;
    logic       wp_d;
    logic       wp_e;
    logic       rom_select_e;
    logic [7:0] seg_de;
    logic       copy_c;
    logic       wp_c;
    logic       shadow_c;
    logic [3:0] seg_c;
  } sccr_shadow_t;

  // Per-bank device sizes.
  typedef struct packed {
    sccr_size_t bank0;
    sccr_size_t bank1;
    sccr_size_t bank2;
    sccr_size_t bank3;
  } sccr_banks_t;

endpackage

// file: hw/sccr_bank_decode.sv
// Decoder of the DRAM bank type fields into per-bank device sizes.
`timescale 1ns/100ps

module sccr_bank_decode (
  // Register contents.
  input  wire logic [7:0]          dram_one_in,
  // Decoded sizes.
  output sccr_pkg::sccr_banks_t    banks_out
);

  // Banks 0/1 depend on the mode bit and the upper type field.
  always_comb begin
    banks_out = '0;
    case ({dram_one_in[7], dram_one_in[6:4]})
      4'h0: banks_out.bank0 = sccr_pkg::SCCR_256K;
      4'h1: begin
        banks_out.bank0 = sccr_pkg::SCCR_256K;
        banks_out.bank1 = sccr_pkg::SCCR_256K;
      end
      4'h2: begin
        banks_out.bank0 = sccr_pkg::SCCR_256K;
        banks_out.bank1 = sccr_pkg::SCCR_1M;
      end
      4'h8: banks_out.bank0 = sccr_pkg::SCCR_1M;
      4'h9: begin
        banks_out.bank0 = sccr_pkg::SCCR_1M;
        banks_out.bank1 = sccr_pkg::SCCR_1M;
      end
      4'ha: begin
        banks_out.bank0 = sccr_pkg::SCCR_1M;
        banks_out.bank1 = sccr_pkg::SCCR_4M;
      end
      4'hb: begin
        banks_out.bank0 = sccr_pkg::SCCR_4M;
        banks_out.bank1 = sccr_pkg::SCCR_1M;
      end
      4'hc: banks_out.bank0 = sccr_pkg::SCCR_4M;
      4'hd: begin
        banks_out.bank0 = sccr_pkg::SCCR_4M;
        banks_out.bank1 = sccr_pkg::SCCR_4M;
      end
      default: banks_out.bank0 = sccr_pkg::SCCR_EMPTY;
    endcase
    // Banks 2/3 ignore the mode bit.
    case (dram_one_in[2:0])
      3'h0: banks_out.bank2 = sccr_pkg::SCCR_1M;
      3'h1: begin
        banks_out.bank2 = sccr_pkg::SCCR_1M;
        banks_out.bank3 = sccr_pkg::SCCR_1M;
      end
      3'h3: begin
        banks_out.bank2 = sccr_pkg::SCCR_4M;
        banks_out.bank3 = sccr_pkg::SCCR_1M;
      end
      3'h4: banks_out.bank2 = sccr_pkg::SCCR_4M;
      3'h5: begin
        banks_out.bank2 = sccr_pkg::SCCR_4M;
        banks_out.bank3 = sccr_pkg::SCCR_4M;
      end
      default: banks_out.bank2 = sccr_pkg::SCCR_EMPTY;
    endcase
  end

endmodule

// file: hw/sccr_strap_sync.sv
// Three-stage synchroniser for the bus clock strap pin.
`timescale 1ns/100ps

module sccr_strap_sync (
  // Clock, reset and enable.
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  // Pin and settled level.
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage; // Stage 0 is read only by stage 1.

  // Shift the pin in; a change counts once stages 1 and 2 agree.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stage     <= 3'h0;
      level_out <= 1'b0;
    end else if (enable_in) begin
      stage <= {stage[1:0], pin_in};
      if (stage[1] == stage[2]) begin
        level_out <= stage[2];
      end
    end
  end

endmodule

// file: hw/sccr_regs.sv
// Indexed configuration register bank of the system controller.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Index via port 22h, data via 24h.
// - Index invalidated after every data access.
// - Reserved bits reset and read zero.
// - Bit 5 adds burst wait; bit 4 clear.
// - Bit 4 opens cache buffer earlier.
// - Single ALE pulse; extra AT wait.
// - Halt before reset; fast CPU reset.
// - Byte swap during bus master cycles.
// - Keyboard reset pulse delayed 2 us or immediate.
// - Parity checking enabled when bit clear.
// - Cache enable disables DRAM burst.
// - Cache size 64KB to 512KB.
// - Cache read burst and write wait.
// - F segment reads ROM or DRAM.
// - D and E shadow, protects, ROM select.
// - Hidden refresh enable, resets disabled.
// - Slow refresh runs four times slower.
// - Eight 16K shadow segment enables D-E.
// - Decode bank types into device sizes.
// - Read and write DRAM wait states.
// - Fast decode off while cache enabled.
// - Bus clock divisor; bit 0 from strap.
// - C segment copy, protect, enable, segments.
// - Noncacheable pin enable, resets set.
module sccr_regs #(
  parameter logic [1:0] REVISION = 2'h2 // Arbitrary revision value.
) (
  // Clock, reset and enable.
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic                   enable_in,
  // Host I/O cycle: one-cycle strobes with address and data.
  input  wire logic [15:0]            io_addr_in,
  input  wire logic                   io_write_in,
  input  wire logic                   io_read_in,
  input  wire logic [7:0]             io_wdata_in,
  output logic [7:0]                  io_rdata_out,
  output logic                        io_rvalid_out,
  // Data bus drive enable, low while the block drives it.
  output logic                        io_oe_n_out,
  // Strap pin and emulated keyboard reset request.
  input  wire logic                   bus_clock_strap_in,
  input  wire logic                   kbd_reset_req_in,
  input  wire logic                   cpu_halt_in,
  // Settings to the state machines.
  output sccr_pkg::sccr_cfg_t         cfg_out,
  output sccr_pkg::sccr_shadow_t      shadow_out,
  output sccr_pkg::sccr_banks_t       banks_out,
  // Expansion bus clock select and keyboard reset pulse.
  output logic [1:0]                  expansion_bus_clock_sel_out,
  output logic                        cpu_reset_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [7:0] regs [8];          // Register contents indexed by offset from 20h.
  logic [7:0] index_reg;         // Held index.
  logic       index_valid;       // Index written and not yet consumed.
  logic       strap_level;       // Settled strap level.
  logic       strap_load;        // Strap still to be captured after reset.
  logic [2:0] strap_wait;        // Cycles until the synchroniser settles.
  sccr_pkg::sccr_banks_t next_banks; // Decoded bank sizes.

  // True when an index lies inside the implemented range.
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = (idx >= sccr_pkg::IDX_CONTROL_ONE) && (idx <= sccr_pkg::IDX_CONTROL_THREE);
  endfunction

  // Writable bit mask of a register slot.
  function automatic logic [7:0] wmask(input logic [2:0] slot);
    case (slot)
      3'h0: wmask = sccr_pkg::WMASK_CONTROL_ONE;
      3'h2: wmask = sccr_pkg::WMASK_SHADOW_ONE;
      3'h4: wmask = sccr_pkg::WMASK_DRAM_ONE;
      3'h5: wmask = sccr_pkg::WMASK_DRAM_TWO;
      3'h6: wmask = sccr_pkg::WMASK_SHADOW_THREE;
      3'h7: wmask = sccr_pkg::WMASK_CONTROL_THREE;
      default: wmask = 8'hff;
    endcase
  endfunction

  logic       data_hit;   // A usable index is held: written and inside the implemented range.
  logic [2:0] slot;       // Register slot of the held index.
  assign slot     = index_reg[2:0];
  assign data_hit = index_valid && idx_ok(index_reg);

  logic       fast_dec;   // Fast decode as it takes effect; off while the cache is on.
  assign fast_dec = regs[5][sccr_pkg::D2_FAST_DEC] & ~regs[1][sccr_pkg::C2_CACHE_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // Index port.

  // The index is taken on a port write and dropped on any data access.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      index_reg   <= 8'h00;
      index_valid <= 1'b0;
    end else if (enable_in) begin
      if (io_write_in && io_addr_in == sccr_pkg::PORT_INDEX) begin
        index_reg   <= io_wdata_in;
        index_valid <= 1'b1;
      end else if ((io_write_in || io_read_in) && io_addr_in == sccr_pkg::PORT_DATA) begin
        index_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.

  sccr_strap_sync u_strap (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .enable_in (enable_in),
    .pin_in    (bus_clock_strap_in),
    .level_out (strap_level)
  );

  // The strap is caught once the synchroniser has settled after reset, so a
  // constant is all that the reset branch loads.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      strap_load <= 1'b1;
      strap_wait <= 3'h4;
    end else if (enable_in && strap_load) begin
      if (strap_wait == 3'h0) begin
        strap_load <= 1'b0;
      end else begin
        strap_wait <= strap_wait - 3'h1;
      end
    end
  end

  // Reset values load here; reserved and read-only bits never take writes.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      regs[0] <= sccr_pkg::RST_CONTROL_ONE;
      regs[1] <= sccr_pkg::RST_CONTROL_TWO;
      regs[2] <= sccr_pkg::RST_SHADOW_ONE;
      regs[3] <= sccr_pkg::RST_SHADOW_TWO;
      regs[4] <= sccr_pkg::RST_DRAM_ONE;
      regs[5] <= sccr_pkg::RST_DRAM_TWO;
      regs[6] <= sccr_pkg::RST_SHADOW_THREE;
      regs[7] <= sccr_pkg::RST_CONTROL_THREE;
    end else if (enable_in) begin
      if (io_write_in && io_addr_in == sccr_pkg::PORT_DATA && data_hit) begin
        regs[slot] <= io_wdata_in & wmask(slot);
      end else if (strap_load && strap_wait == 3'h0) begin
        regs[5][sccr_pkg::D2_CLK_STRAP] <= strap_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads.

  // A read answers one cycle later; an unmapped index leaves the bus undriven.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      io_rdata_out  <= 8'h00;
      io_rvalid_out <= 1'b0;
      io_oe_n_out   <= 1'b1;
    end else if (enable_in) begin
      io_rvalid_out <= 1'b0;
      io_oe_n_out   <= 1'b1;
      if (io_read_in && io_addr_in == sccr_pkg::PORT_DATA && data_hit) begin
        io_rvalid_out <= 1'b1;
        io_oe_n_out   <= 1'b0;
        if (slot == 3'h0) begin
          io_rdata_out <= {REVISION, regs[0][5:0]};
        end else begin
          io_rdata_out <= regs[slot];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded settings.

  sccr_bank_decode u_banks (
    .dram_one_in (regs[4]),
    .banks_out   (next_banks)
  );

  // All settings are registered so every output leaves a flip-flop.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_out    <= '0;
      shadow_out <= '0;
      banks_out  <= '0;
      expansion_bus_clock_sel_out <= 2'h0;
    end else if (enable_in) begin
      banks_out <= next_banks;
      expansion_bus_clock_sel_out <= regs[5][1:0];
      // Bit 4 is dropped while bit 5 adds the burst wait, a safe reading.
      cfg_out.burst_wait <= regs[0][sccr_pkg::C1_BURST_WAIT];
      cfg_out.early_oe   <= regs[0][sccr_pkg::C1_EARLY_OE] &
                            ~regs[0][sccr_pkg::C1_BURST_WAIT];
      cfg_out.single_ale <= regs[0][sccr_pkg::C1_SINGLE_ALE];
      cfg_out.at_wait    <= regs[0][sccr_pkg::C1_AT_WAIT];
      cfg_out.halt_reset <= regs[0][sccr_pkg::C1_HALT_RESET];
      cfg_out.fast_reset <= regs[0][sccr_pkg::C1_FAST_RESET];
      cfg_out.byte_swap  <= regs[1][sccr_pkg::C2_BYTE_SWAP];
      cfg_out.kbd_now    <= regs[1][sccr_pkg::C2_KBD_NOW];
      cfg_out.parity_en  <= ~regs[1][sccr_pkg::C2_PARITY_OFF];
      cfg_out.cache_en   <= regs[1][sccr_pkg::C2_CACHE_EN];
      cfg_out.dram_burst <= ~regs[1][sccr_pkg::C2_CACHE_EN];
      cfg_out.cache_size <= regs[1][sccr_pkg::C2_SIZE_LO +: 2];
      cfg_out.read_fast  <= regs[1][sccr_pkg::C2_READ_FAST];
      cfg_out.write_zero <= regs[1][sccr_pkg::C2_WRITE_ZERO];
      cfg_out.hidden_en  <= ~regs[2][sccr_pkg::S1_HIDDEN_OFF];
      cfg_out.slow_refresh <= regs[2][sccr_pkg::S1_SLOW_REF];
      cfg_out.noncache_en  <= regs[7][sccr_pkg::C3_NONCACHE];
      cfg_out.fast_decode  <= fast_dec;
      // Read base 3 plus 0..2 (code 00 unused, treated as 0); write base 2 plus 0..3.
      cfg_out.read_wait  <= sccr_pkg::READ_BASE_WAIT
                            + ((regs[5][7:6] == 2'h0) ? 3'h0 : {1'b0, regs[5][7:6] - 2'h1})
                            - {2'h0, fast_dec};
      cfg_out.write_wait <= sccr_pkg::WRITE_BASE_WAIT + {1'b0, regs[5][5:4]}
                            - {2'h0, fast_dec};
      cfg_out.clk_select <= regs[5][1:0];
      shadow_out.rom_f    <= regs[2][sccr_pkg::S1_ROM_F];
      shadow_out.shadow_d <= regs[2][sccr_pkg::S1_SHADOW_D];
      shadow_out.shadow_e <= regs[2][sccr_pkg::S1_SHADOW_E];
      shadow_out.wp_d     <= regs[2][sccr_pkg::S1_WP_D];
      shadow_out.wp_e     <= regs[2][sccr_pkg::S1_WP_E];
      shadow_out.rom_select_e <= ~regs[2][sccr_pkg::S1_SHADOW_E];
      shadow_out.seg_de   <= regs[3];
      shadow_out.copy_c   <= regs[6][sccr_pkg::S3_COPY];
      shadow_out.wp_c     <= regs[6][sccr_pkg::S3_WP_C];
      shadow_out.shadow_c <= regs[6][sccr_pkg::S3_SHADOW_C];
      shadow_out.seg_c    <= regs[6][3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Emulated keyboard reset.

  typedef enum logic [1:0] {SCCR_KB_IDLE, SCCR_KB_HALT, SCCR_KB_DELAY, SCCR_KB_PULSE} sccr_kb_t;
  sccr_kb_t   kb_state;   // Keyboard reset sequencer state.
  logic [7:0] kb_count;   // Delay counter.

  // A request may wait for a halt, then for the delay, then pulses one cycle.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      kb_state      <= SCCR_KB_IDLE;
      kb_count      <= 8'h00;
      cpu_reset_out <= 1'b0;
    end else if (enable_in) begin
      cpu_reset_out <= 1'b0;
      case (kb_state)
        SCCR_KB_IDLE: begin
          kb_count <= 8'(sccr_pkg::KBD_DELAY_CYC - 1);
          if (kbd_reset_req_in) begin
            kb_state <= regs[0][sccr_pkg::C1_HALT_RESET] ? SCCR_KB_HALT : SCCR_KB_DELAY;
          end
        end
        SCCR_KB_HALT: begin
          if (cpu_halt_in) begin
            kb_state <= SCCR_KB_DELAY;
          end
        end
        SCCR_KB_DELAY: begin
          if (regs[1][sccr_pkg::C2_KBD_NOW] || kb_count == 8'h00) begin
            kb_state <= SCCR_KB_PULSE;
          end else begin
            kb_count <= kb_count - 8'h01;
          end
        end
        SCCR_KB_PULSE: begin
          cpu_reset_out <= 1'b1;
          kb_state      <= SCCR_KB_IDLE;
        end
        default: begin
          kb_state <= SCCR_KB_IDLE;
        end
      endcase
    end
  end

endmodule

// file: sim/sccr_regs_checker.sv
// Checker of the port behaviour of the configuration register bank.
`timescale 1ns/100ps
module sccr_regs_checker (
  // Clock, reset and enable.
  input wire logic                   clock_in,
  input wire logic                   rst_in,
  input wire logic                   enable_in,
  // Host I/O cycle.
  input wire logic [15:0]            io_addr_in,
  input wire logic                   io_write_in,
  input wire logic                   io_read_in,
  input wire logic [7:0]             io_wdata_in,
  input wire logic [7:0]             io_rdata_out,
  input wire logic                   io_rvalid_out,
  input wire logic                   io_oe_n_out,
  // Settings.
  input wire sccr_pkg::sccr_cfg_t    cfg_out,
  input wire sccr_pkg::sccr_shadow_t shadow_out
);
  logic       idx_ok; // A fresh in-range index is held.
  logic [1:0] age;    // Cycles since reset, saturating.
  logic       rd_dat; // Read strobe at the data port.
  assign rd_dat = enable_in && io_read_in && io_addr_in == sccr_pkg::PORT_DATA;
  //////////////////////////////////////////////////////////////////////////////
  // Track the index as the host sees it; any data access spends it.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      idx_ok <= 1'b0;
    end else if (enable_in && io_write_in && io_addr_in == sccr_pkg::PORT_INDEX) begin
      idx_ok <= io_wdata_in[7:3] == 5'h04;
    end else if (enable_in && (io_read_in || io_write_in) && io_addr_in == sccr_pkg::PORT_DATA) begin
      idx_ok <= 1'b0;
    end
  end
  // Settings lag reset by an edge, so the burst and E-area checks judge them only once settled.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_read_answered: assert property (rd_dat && idx_ok |=> io_rvalid_out && !io_oe_n_out)
    else $error("read not answered");
  a_stale_refused: assert property (rd_dat && !idx_ok |=> !io_rvalid_out && io_oe_n_out)
    else $error("stale read answered");
  a_single_answer: assert property (io_rvalid_out |=> !io_rvalid_out)
    else $error("answer too long");
  a_answer_cause: assert property (io_rvalid_out |-> $past(rd_dat))
    else $error("answer without read");
  a_drive_tied: assert property (io_oe_n_out == !io_rvalid_out)
    else $error("data drive enable not tied to answer");
  a_rdata_hold: assert property (!io_rvalid_out |-> $stable(io_rdata_out))
    else $error("read data moved");
  a_burst_off: assert property (age == 2'h3 |-> cfg_out.dram_burst == !cfg_out.cache_en)
    else $error("burst not inverse of cache");
  a_fast_masked: assert property (cfg_out.cache_en |-> !cfg_out.fast_decode)
    else $error("fast decode with cache");
  a_early_masked: assert property (cfg_out.burst_wait |-> !cfg_out.early_oe)
    else $error("early enable set with burst wait");
  a_rom_sel_e: assert property (age == 2'h3 |-> shadow_out.rom_select_e == !shadow_out.shadow_e)
    else $error("E area select not opposite to shadow");
endmodule

bind sccr_regs sccr_regs_checker u_checker (.*);

// file: sim/sccr_host_model.sv
// Host model that issues I/O port cycles to the register bank.
`timescale 1ns/100ps
module sccr_host_model (
  // Clock and answer.
  input  wire logic        clock_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        rvalid_in,
  // Request.
  output logic [15:0]      addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       wdata_out
);
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One strobe cycle; released lines are inverted so stale values never match.
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    wr_out = w;
    rd_out = !w;
    wdata_out = d;
    @(negedge clock_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // Data read; the answer is taken one cycle after the strobe.
  task automatic data_rd(output logic [7:0] d, output logic ok);
    cyc(sccr_pkg::PORT_DATA, 1'b0, 8'h00);
    ok = rvalid_in;
    d = rdata_in;
  endtask
  // Each register write and read is preceded by its own index write; data_rd alone is not.
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    cyc(sccr_pkg::PORT_INDEX, 1'b1, idx);
    cyc(sccr_pkg::PORT_DATA, 1'b1, d);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    cyc(sccr_pkg::PORT_INDEX, 1'b1, idx);
    data_rd(d, ok);
  endtask
endmodule

// file: sim/tb_system_controller_config_regs.sv
// Testbench of the configuration register bank.
`timescale 1ns/100ps
module tb_system_controller_config_regs;
  logic                   clock_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic [15:0]            addr;
  logic                   wr, rd, rvalid, oe_n, cpu_rst, ok;
  logic [7:0]             wdata, rdata, d;
  logic                   strap = 1'b1;
  logic                   kbd = 1'b0, halt = 1'b0;
  logic [1:0]             clk_sel;
  sccr_pkg::sccr_cfg_t    cfg;
  sccr_pkg::sccr_banks_t  banks;
  sccr_pkg::sccr_shadow_t shadow;
  int                     err_total = 0, n_tests = 0, cycles = 0;
  always #50 clock_in = ~clock_in;
  sccr_regs dut (
    .clock_in(clock_in), .rst_in(rst_in), .enable_in(1'b1),
    .io_addr_in(addr), .io_write_in(wr), .io_read_in(rd), .io_wdata_in(wdata),
    .io_rdata_out(rdata), .io_rvalid_out(rvalid), .io_oe_n_out(oe_n),
    .bus_clock_strap_in(strap), .kbd_reset_req_in(kbd), .cpu_halt_in(halt),
    .cfg_out(cfg), .shadow_out(shadow), .banks_out(banks),
    .expansion_bus_clock_sel_out(clk_sel), .cpu_reset_out(cpu_rst)
  );
  sccr_host_model host (
    .clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] want, input logic [7:0] got);
    n_tests++;
    if (got !== want) begin
      $display("unexpected %s expected %h seen %h", name, want, got);
      err_total++;
    end
  endtask
  // Reset value, then ones and zeros; read-only and reserved bits stay clear, except the revision bits of the first register.
  task automatic t_registers();
    logic [7:0] want [8];
    logic [7:0] mask [8];
    logic [7:0] rev;
    want = '{8'h80, 8'h00, 8'h84, 8'h00, 8'h87, 8'hf1, 8'h00, 8'h80};
    mask = '{8'h3f, 8'hff, 8'hfd, 8'hff, 8'hf7, 8'hfb, 8'h7f, 8'h80};
    for (int i = 0; i < 8; i++) begin
      rev = (i == 0) ? 8'h80 : 8'h00;
      host.reg_rd(8'h20 + i[7:0], d, ok);
      chk("reset answer", 8'h01, {7'h0, ok});
      chk("reset value", want[i], d);
      host.reg_wr(8'h20 + i[7:0], 8'hff);
      host.reg_rd(8'h20 + i[7:0], d, ok);
      chk("ones readback", mask[i] | rev, d);
      host.reg_wr(8'h20 + i[7:0], 8'h00);
      host.reg_rd(8'h20 + i[7:0], d, ok);
      chk("zeros readback", rev, d);
    end
    $display("test registers done");
  endtask
  task automatic t_index_rules();
    host.reg_wr(sccr_pkg::IDX_SHADOW_TWO, 8'h5a);
    host.data_rd(d, ok);
    chk("spent index answer", 8'h00, {7'h0, ok});
    host.cyc(sccr_pkg::PORT_DATA, 1'b1, 8'h33);
    host.reg_wr(8'h30, 8'hff);
    host.reg_rd(8'h30, d, ok);
    chk("unmapped answer", 8'h00, {7'h0, ok});
    chk("unmapped drive", 8'h01, {7'h0, oe_n});
    host.reg_rd(sccr_pkg::IDX_SHADOW_TWO, d, ok);
    chk("segments kept", 8'h5a, d);
    chk("segment map", 8'h5a, shadow.seg_de);
    chk("bank sizes", 8'h48, banks);
    host.reg_rd(sccr_pkg::IDX_CONTROL_ONE, d, ok);
    chk("first register kept", 8'h80, d);
    $display("test index rules done");
  endtask
  task automatic t_settings();
    host.reg_wr(sccr_pkg::IDX_DRAM_TWO, 8'h08);
    host.reg_wr(sccr_pkg::IDX_CONTROL_TWO, 8'h3e);
    repeat (2) @(negedge clock_in);
    chk("burst mode", 8'h00, {7'h0, cfg.dram_burst});
    chk("fast decode", 8'h00, {7'h0, cfg.fast_decode});
    chk("cache size", 8'h03, {6'h0, cfg.cache_size});
    chk("parity", 8'h00, {7'h0, cfg.parity_en});
    chk("read wait", 8'h03, {5'h0, cfg.read_wait});
    host.reg_wr(sccr_pkg::IDX_CONTROL_TWO, 8'h00);
    host.reg_wr(sccr_pkg::IDX_DRAM_TWO, 8'hba);
    repeat (2) @(negedge clock_in);
    chk("fast decode on", 8'h01, {7'h0, cfg.fast_decode});
    chk("read wait fast", 8'h03, {5'h0, cfg.read_wait});
    chk("write wait fast", 8'h04, {5'h0, cfg.write_wait});
    chk("clock select", 8'h02, {6'h0, clk_sel});
    $display("test settings done");
  endtask
  task automatic kbd_delay(output int n);
    @(negedge clock_in);
    kbd = 1'b1;
    @(negedge clock_in);
    kbd = 1'b0;
    n = 0;
    while (cpu_rst !== 1'b1 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
  endtask
  task automatic t_kbd_timing();
    int fast, slow;
    host.reg_wr(sccr_pkg::IDX_CONTROL_TWO, 8'h40);
    kbd_delay(fast);
    host.reg_wr(sccr_pkg::IDX_CONTROL_TWO, 8'h00);
    kbd_delay(slow);
    chk("immediate pulse", 8'h01, {7'h0, fast < 6});
    chk("delayed pulse", 8'h01, {7'h0, slow - fast >= 19 && slow - fast <= 21});
    host.reg_wr(sccr_pkg::IDX_CONTROL_ONE, 8'h02);
    kbd_delay(slow);
    chk("halt wait", 8'h28, slow[7:0]);
    halt = 1'b1;
    kbd_delay(fast);
    chk("pulse after halt", 8'h01, {7'h0, fast < 40});
    $display("test keyboard reset done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang costs a mismatch.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (6) @(negedge clock_in);
    t_registers();
    t_index_rules();
    t_settings();
    t_kbd_timing();
    end_of_test();
  end
endmodule
